// >>> hdl/asr_defs.vh
// Constants for the sample-rate and clock-domain control block.
// Assumes a 200 MHz core clock and a 16-bit register port with word addresses.
`ifndef ASR_DEFS_VH
`define ASR_DEFS_VH

// Clock figures
`define ASR_CORE_CLK_HZ 32'h0bebc200
`define ASR_PERIOD_MAX 17'h1ffff
`define ASR_STABLE_COUNT 2'h2
`define ASR_TOL_SHIFT 6

// Register offsets
`define ASR_REG_SYS_FREQ 16'h0100
`define ASR_REG_SYNC_RATE1 16'h0102
`define ASR_REG_SYNC_RATE2 16'h0103
`define ASR_REG_SYNC_RATE3 16'h0104
`define ASR_REG_ASYNC_RATE1 16'h0112
`define ASR_REG_ASYNC_RATE2 16'h0113
`define ASR_REG_SYNC_APPL1 16'h0122
`define ASR_REG_SYNC_APPL2 16'h0123
`define ASR_REG_SYNC_APPL3 16'h0124
`define ASR_REG_ASYNC_APPL1 16'h0132
`define ASR_REG_ASYNC_APPL2 16'h0133
`define ASR_REG_DET_CTRL 16'h0140
`define ASR_REG_DET_RATE1 16'h0141
`define ASR_REG_DET_RATE2 16'h0142
`define ASR_REG_DET_RATE3 16'h0143
`define ASR_REG_DET_RATE4 16'h0144
`define ASR_REG_DET_STS 16'h0145
`define ASR_REG_PORT_RATE 16'h0150
`define ASR_REG_CORE_LIMIT 16'h0161

// Field positions, reset values and the core rate cap
`define ASR_DET_ENA_BIT 0
`define ASR_DET_TRIG_BIT 4
`define ASR_RATE_RST 5'h03
`define ASR_FREQ_RST 3'h0
`define ASR_CORE_CAP 3'h2

`endif

// >>> hdl/asr_rate_apply.v
// One rate selector: written value waits for its domain's sample boundary.
// Assumes the boundary tick is already a one-cycle pulse in core_clk domain.
`timescale 1ns/1ps
`include "asr_defs.vh"

module asr_rate_apply
(
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Requested value
  input wire [4:0] rate_req,
  // Sample boundary of the owning domain
  input wire boundary_tick,
  // Value actually in use
  output reg [4:0] rate_applied
);

  ////////////////////////////////////////
  // Change only on a boundary so no active path sees a half-sample switch
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rate_applied <= `ASR_RATE_RST;
    end
    else if (boundary_tick)
    begin
      rate_applied <= rate_req;
    end
  end

endmodule // asr_rate_apply

// >>> hdl/asr_frame_meter.v
// Frame clock period meter: counts core clocks between rising frame edges.
// Assumes frame_in is asynchronous; it is synchronised before any use.
`timescale 1ns/1ps
`include "asr_defs.vh"

module asr_frame_meter
(
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Restart the measurement
  input wire clear,
  // Frame clock pin
  input wire frame_in,
  // Measured period and its strobe
  output reg [16:0] period,
  output reg period_valid,
  // Frame clock stopped
  output reg stalled
);

  reg sync_a; // First stage, read only by sync_b
  reg sync_b; // Second stage
  reg sync_d; // Delayed copy for edge finding
  reg [16:0] count; // Cycles since last edge
  reg seen_edge; // First edge only starts counting
  wire rise;

  assign rise = sync_b & ~sync_d;

  ////////////////////////////////////////
  // Two-flop synchroniser and edge delay
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_d <= 1'b0;
    end
    else
    begin
      sync_a <= frame_in;
      sync_b <= sync_a;
      sync_d <= sync_b;
    end
  end

  ////////////////////////////////////////
  // Period counter; saturates so a stopped clock is seen as stalled
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      count <= 17'h00000;
      seen_edge <= 1'b0;
      period <= 17'h00000;
      period_valid <= 1'b0;
      stalled <= 1'b0;
    end
    else
    begin
      period_valid <= 1'b0;
      if (clear)
      begin
        // Partial period after a source change is thrown away
        count <= 17'h00000;
        seen_edge <= 1'b0;
        stalled <= 1'b0;
      end
      else if (rise)
      begin
        count <= 17'h00001;
        seen_edge <= 1'b1;
        stalled <= 1'b0;
        if (seen_edge)
        begin
          period <= count;
          period_valid <= 1'b1;
        end
      end
      else if (count != `ASR_PERIOD_MAX)
      begin
        count <= count + 17'h00001;
      end
      else
      begin
        stalled <= 1'b1;
      end
    end
  end

endmodule // asr_frame_meter

// >>> hdl/asr_ctrl.v
// Sample-rate control: rate selectors with boundary apply, core clock limit,
// port rate mapping and automatic frame-rate detection.
// Assumes sample boundary ticks and frame clocks arrive from other domains.
`timescale 1ns/1ps
`include "asr_defs.vh"

module asr_ctrl
(
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Register port
  input wire [15:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // Sample boundaries of the two system clock domains
  input wire main_system_clock_tick,
  input wire async_system_clock_tick,
  // Audio port frame clocks and slave mode flags
  input wire [2:0] frame_clk_in,
  input wire [2:0] port_slave,
  // Core rate cap and per-port rate
  output reg [2:0] core_rate_code,
  output reg [4:0] port_rate_one,
  output reg [4:0] port_rate_two,
  output reg [4:0] port_rate_three,
  output reg [2:0] port_async,
  // Control write sequence launch
  output reg seq_start,
  output reg [1:0] seq_index
);

  ////////////////////////////////////////
  // Register storage
  reg [2:0] sys_freq; // System clock frequency code
  reg core_clock_limit_sel; // High core rate allowed
  reg [4:0] sync_rate_sel [0:2]; // Requested sync rates
  reg [4:0] async_rate_select [0:1]; // Requested async rates
  reg rate_detect_enable;
  reg [1:0] frame_clock_source_sel;
  reg trigger_on_first_detect;
  reg [4:0] det_rate [0:3]; // Detection candidates
  reg [8:0] port_rate_sel; // Three 3-bit indices into five rates
  wire [4:0] sync_rate_applied [0:2];
  wire [4:0] async_rate_applied [0:1];
  wire [4:0] five_rate [0:4];

  // Boundary tick synchronisers
  reg [2:0] sys_tick_sync; // [0] read only by [1]
  reg [2:0] async_tick_sync;
  wire sys_boundary;
  wire async_boundary;

  // Detection state
  wire [16:0] period;
  wire period_valid;
  wire stalled;
  wire frame_sel;
  wire det_active;
  reg det_active_d; // Detect re-enable
  reg [1:0] src_d; // Detect source change
  wire meter_clear;
  reg [1:0] cand_idx; // Matching candidate this period
  reg cand_hit;
  reg [1:0] stable_idx;
  reg [1:0] stable_cnt;
  reg det_valid; // A candidate is currently detected
  reg [1:0] det_idx;
  reg first_done; // First matching detection already seen
  reg force_next; // Next detection fires regardless
  integer i;
  integer j; // Candidate loop, apart from the reset loops

  ////////////////////////////////////////
  // Nominal frame period in core clocks for a rate code, zero if unknown
  function [16:0] nominal_period;
    input [4:0] code;
    reg [31:0] hz;
    reg [31:0] cyc;
    begin
      case (code)
        5'h01: hz = 32'h00002ee0; // 12kHz
        5'h02: hz = 32'h00005dc0; // 24kHz
        5'h03: hz = 32'h0000bb80; // 48kHz
        5'h04: hz = 32'h00017700; // 96kHz
        5'h05: hz = 32'h0002ee00; // 192kHz
        5'h10: hz = 32'h00000fa0; // 4kHz
        5'h11: hz = 32'h00001f40; // 8kHz
        5'h12: hz = 32'h00003e80; // 16kHz
        5'h13: hz = 32'h00007d00; // 32kHz
        5'h09: hz = 32'h00002b11; // 11.025kHz
        5'h0a: hz = 32'h00005622; // 22.05kHz
        5'h0b: hz = 32'h0000ac44; // 44.1kHz
        5'h0c: hz = 32'h00015888; // 88.2kHz
        5'h0d: hz = 32'h0002b110; // 176.4kHz
        default: hz = 32'h00000000; // Unsupported code never matches
      endcase
      if (hz == 32'h00000000)
      begin
        cyc = 32'h00000000;
      end
      else
      begin
        cyc = (`ASR_CORE_CLK_HZ + (hz >> 1)) / hz;
      end
      nominal_period = cyc[16:0];
    end
  endfunction

  ////////////////////////////////////////
  // Register writes
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sys_freq <= `ASR_FREQ_RST;
      core_clock_limit_sel <= 1'b0;
      for (i = 0; i < 3; i = i + 1)
        sync_rate_sel[i] <= `ASR_RATE_RST;
      for (i = 0; i < 2; i = i + 1)
        async_rate_select[i] <= `ASR_RATE_RST;
      for (i = 0; i < 4; i = i + 1)
        det_rate[i] <= 5'h00;
      rate_detect_enable <= 1'b0;
      frame_clock_source_sel <= 2'h0;
      trigger_on_first_detect <= 1'b0;
      port_rate_sel <= 9'h000;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `ASR_REG_SYS_FREQ: sys_freq <= reg_wdata[2:0];
        `ASR_REG_CORE_LIMIT: core_clock_limit_sel <= reg_wdata[0];
        `ASR_REG_SYNC_RATE1: sync_rate_sel[0] <= reg_wdata[4:0];
        `ASR_REG_SYNC_RATE2: sync_rate_sel[1] <= reg_wdata[4:0];
        `ASR_REG_SYNC_RATE3: sync_rate_sel[2] <= reg_wdata[4:0];
        `ASR_REG_ASYNC_RATE1: async_rate_select[0] <= reg_wdata[4:0];
        `ASR_REG_ASYNC_RATE2: async_rate_select[1] <= reg_wdata[4:0];
        `ASR_REG_DET_CTRL:
        begin
          rate_detect_enable <= reg_wdata[`ASR_DET_ENA_BIT];
          frame_clock_source_sel <= reg_wdata[2:1];
          trigger_on_first_detect <= reg_wdata[`ASR_DET_TRIG_BIT];
        end
        `ASR_REG_DET_RATE1: det_rate[0] <= reg_wdata[4:0];
        `ASR_REG_DET_RATE2: det_rate[1] <= reg_wdata[4:0];
        `ASR_REG_DET_RATE3: det_rate[2] <= reg_wdata[4:0];
        `ASR_REG_DET_RATE4: det_rate[3] <= reg_wdata[4:0];
        `ASR_REG_PORT_RATE: port_rate_sel <= reg_wdata[8:0];
        default: sys_freq <= sys_freq; // Unmapped writes are dropped
      endcase
    end
  end

  ////////////////////////////////////////
  // Register reads, answered on the next edge
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata <= 16'h0000;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        `ASR_REG_SYS_FREQ: reg_rdata <= {13'h0000, sys_freq};
        `ASR_REG_CORE_LIMIT: reg_rdata <= {15'h0000, core_clock_limit_sel};
        `ASR_REG_SYNC_RATE1: reg_rdata <= {11'h000, sync_rate_sel[0]};
        `ASR_REG_SYNC_RATE2: reg_rdata <= {11'h000, sync_rate_sel[1]};
        `ASR_REG_SYNC_RATE3: reg_rdata <= {11'h000, sync_rate_sel[2]};
        `ASR_REG_ASYNC_RATE1: reg_rdata <= {11'h000, async_rate_select[0]};
        `ASR_REG_ASYNC_RATE2: reg_rdata <= {11'h000, async_rate_select[1]};
        `ASR_REG_SYNC_APPL1: reg_rdata <= {11'h000, sync_rate_applied[0]};
        `ASR_REG_SYNC_APPL2: reg_rdata <= {11'h000, sync_rate_applied[1]};
        `ASR_REG_SYNC_APPL3: reg_rdata <= {11'h000, sync_rate_applied[2]};
        `ASR_REG_ASYNC_APPL1: reg_rdata <= {11'h000, async_rate_applied[0]};
        `ASR_REG_ASYNC_APPL2: reg_rdata <= {11'h000, async_rate_applied[1]};
        `ASR_REG_DET_CTRL: reg_rdata <= {11'h000, trigger_on_first_detect, 1'b0,
                                         frame_clock_source_sel, rate_detect_enable};
        `ASR_REG_DET_RATE1: reg_rdata <= {11'h000, det_rate[0]};
        `ASR_REG_DET_RATE2: reg_rdata <= {11'h000, det_rate[1]};
        `ASR_REG_DET_RATE3: reg_rdata <= {11'h000, det_rate[2]};
        `ASR_REG_DET_RATE4: reg_rdata <= {11'h000, det_rate[3]};
        `ASR_REG_DET_STS: reg_rdata <= {13'h0000, det_valid, det_idx};
        `ASR_REG_PORT_RATE: reg_rdata <= {7'h00, port_rate_sel};
        default: reg_rdata <= 16'h0000; // Unmapped reads give zero
      endcase
    end
  end

  ////////////////////////////////////////
  // Each domain's boundary is synchronised on its own; they never share a tick
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sys_tick_sync <= 3'h0;
      async_tick_sync <= 3'h0;
    end
    else
    begin
      sys_tick_sync <= {sys_tick_sync[1:0], main_system_clock_tick};
      async_tick_sync <= {async_tick_sync[1:0], async_system_clock_tick};
    end
  end

  assign sys_boundary = sys_tick_sync[1] & ~sys_tick_sync[2];
  assign async_boundary = async_tick_sync[1] & ~async_tick_sync[2];

  ////////////////////////////////////////
  // Five selectors, each applied at its own domain boundary
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_sync
      asr_rate_apply u_apply
      (
        .core_clk(core_clk),
        .rst(rst),
        .rate_req(sync_rate_sel[g]),
        .boundary_tick(sys_boundary),
        .rate_applied(sync_rate_applied[g])
      );
    end
    for (g = 0; g < 2; g = g + 1)
    begin : g_async
      asr_rate_apply u_apply
      (
        .core_clk(core_clk),
        .rst(rst),
        .rate_req(async_rate_select[g]),
        .boundary_tick(async_boundary),
        .rate_applied(async_rate_applied[g])
      );
    end
  endgenerate

  // Index 0..2 sync, 3..4 async; five rates at most
  assign five_rate[0] = sync_rate_applied[0];
  assign five_rate[1] = sync_rate_applied[1];
  assign five_rate[2] = sync_rate_applied[2];
  assign five_rate[3] = async_rate_applied[0];
  assign five_rate[4] = async_rate_applied[1];

  ////////////////////////////////////////
  // Core rate cap and port rate mapping; indices above four fall back to 0
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      core_rate_code <= `ASR_FREQ_RST;
      port_rate_one <= `ASR_RATE_RST;
      port_rate_two <= `ASR_RATE_RST;
      port_rate_three <= `ASR_RATE_RST;
      port_async <= 3'h0;
    end
    else
    begin
      if (!core_clock_limit_sel && sys_freq > `ASR_CORE_CAP)
        core_rate_code <= `ASR_CORE_CAP;
      else
        core_rate_code <= sys_freq;
      port_rate_one <= five_rate[(port_rate_sel[2:0] > 3'h4) ? 3'h0 : port_rate_sel[2:0]];
      port_rate_two <= five_rate[(port_rate_sel[5:3] > 3'h4) ? 3'h0 : port_rate_sel[5:3]];
      port_rate_three <= five_rate[(port_rate_sel[8:6] > 3'h4) ? 3'h0 : port_rate_sel[8:6]];
      port_async <= {(port_rate_sel[8:6] == 3'h3) || (port_rate_sel[8:6] == 3'h4),
                     (port_rate_sel[5:3] == 3'h3) || (port_rate_sel[5:3] == 3'h4),
                     (port_rate_sel[2:0] == 3'h3) || (port_rate_sel[2:0] == 3'h4)};
    end
  end

  ////////////////////////////////////////
  // Detection runs only when enabled and the chosen port is a slave
  assign frame_sel = (frame_clock_source_sel == 2'h1) ? frame_clk_in[1] :
                     (frame_clock_source_sel == 2'h2) ? frame_clk_in[2] : frame_clk_in[0];
  assign det_active = rate_detect_enable && (frame_clock_source_sel != 2'h3) &&
                      port_slave[frame_clock_source_sel];
  assign meter_clear = !det_active || (src_d != frame_clock_source_sel);

  asr_frame_meter u_meter
  (
    .core_clk(core_clk),
    .rst(rst),
    .clear(meter_clear),
    .frame_in(frame_sel),
    .period(period),
    .period_valid(period_valid),
    .stalled(stalled)
  );

  ////////////////////////////////////////
  // Compare a measured period with the four candidates within tolerance
  always @*
  begin
    cand_hit = 1'b0;
    cand_idx = 2'h0;
    for (j = 3; j >= 0; j = j - 1)
    begin
      if (nominal_period(det_rate[j]) != 17'h00000 &&
          period <= nominal_period(det_rate[j]) + (nominal_period(det_rate[j]) >> `ASR_TOL_SHIFT) &&
          period + (nominal_period(det_rate[j]) >> `ASR_TOL_SHIFT) >= nominal_period(det_rate[j]))
      begin
        cand_hit = 1'b1;
        cand_idx = j[1:0];
      end
    end
  end

  ////////////////////////////////////////
  // Stable match tracking and sequence launch decision
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      det_active_d <= 1'b0;
      src_d <= 2'h0;
      stable_idx <= 2'h0;
      stable_cnt <= 2'h0;
      det_valid <= 1'b0;
      det_idx <= 2'h0;
      first_done <= 1'b0;
      force_next <= 1'b0;
      seq_start <= 1'b0;
      seq_index <= 2'h0;
    end
    else
    begin
      seq_start <= 1'b0;
      det_active_d <= det_active;
      src_d <= frame_clock_source_sel;
      if ((det_active && !det_active_d) || (src_d != frame_clock_source_sel))
      begin
        // Re-enable or new source: if a detection was already seen, next match fires whatever the setting
        force_next <= first_done;
        stable_cnt <= 2'h0;
        det_valid <= 1'b0;
      end
      else if (!det_active || stalled)
      begin
        stable_cnt <= 2'h0;
        det_valid <= 1'b0;
      end
      else if (period_valid)
      begin
        if (!cand_hit)
        begin
          // Off-candidate rate: nothing reported
          stable_cnt <= 2'h0;
          det_valid <= 1'b0;
        end
        else if (cand_hit && (stable_cnt == 2'h0 || cand_idx != stable_idx))
        begin
          stable_idx <= cand_idx;
          stable_cnt <= 2'h1;
        end
        else if (stable_cnt + 2'h1 < `ASR_STABLE_COUNT)
        begin
          stable_cnt <= stable_cnt + 2'h1;
        end
        else if (!det_valid || det_idx != stable_idx)
        begin
          // Newly confirmed candidate
          det_valid <= 1'b1;
          det_idx <= stable_idx;
          stable_cnt <= `ASR_STABLE_COUNT;
          first_done <= 1'b1;
          force_next <= 1'b0;
          if (trigger_on_first_detect || force_next)
          begin
            seq_start <= 1'b1;
            seq_index <= stable_idx;
          end
          else if (first_done && det_idx != stable_idx)
          begin
            seq_start <= 1'b1;
            seq_index <= stable_idx;
          end
        end
      end
    end
  end

endmodule // asr_ctrl

// >>> test/asr_ctrl_sva.sv
// Checker for the sample-rate control block, watching its ports only.
// Assumes the register offsets and field positions of asr_defs.vh.
`timescale 1ns/1ps
`include "asr_defs.vh"

module asr_ctrl_sva
(
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Register port
  input wire [15:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  // Port modes and outputs
  input wire [2:0] port_slave,
  input wire [2:0] core_rate_code,
  input wire seq_start,
  input wire [1:0] seq_index
);
  ////////////////////////////////////////
  // Shadow copies of control fields, taken from the writes
  reg lim;
  reg lim_d;
  reg lim_d2;
  reg [2:0] sysf;
  reg en;
  reg [1:0] src;

  // Delayed limit copies cover the output's register stage
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      lim <= 1'b0;
      lim_d <= 1'b0;
      lim_d2 <= 1'b0;
      sysf <= 3'h0;
      en <= 1'b0;
      src <= 2'h0;
    end
    else
    begin
      lim_d <= lim;
      lim_d2 <= lim_d;
      if (reg_wr && reg_addr == `ASR_REG_CORE_LIMIT)
        lim <= reg_wdata[0];
      if (reg_wr && reg_addr == `ASR_REG_SYS_FREQ)
        sysf <= reg_wdata[2:0];
      if (reg_wr && reg_addr == `ASR_REG_DET_CTRL)
      begin
        en <= reg_wdata[`ASR_DET_ENA_BIT];
        src <= reg_wdata[2:1];
      end
    end
  end

  ////////////////////////////////////////
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  property p_seq_pulse;
    seq_start |=> !seq_start;
  endproperty
  a_seq_pulse: assert property (p_seq_pulse) else $error("launch longer than a cycle");

  property p_idx_hold;
    $changed(seq_index) |-> seq_start;
  endproperty
  a_idx_hold: assert property (p_idx_hold) else $error("index moved without launch");

  property p_seq_en;
    seq_start |-> $past(en);
  endproperty
  a_seq_en: assert property (p_seq_en) else $error("launch with detection disabled");

  property p_seq_slave;
    seq_start |-> src != 2'h3 && port_slave[src];
  endproperty
  a_seq_slave: assert property (p_seq_slave) else $error("launch from a master port");

  property p_core_cap;
    !(lim || lim_d || lim_d2) |-> core_rate_code <= `ASR_CORE_CAP;
  endproperty
  a_core_cap: assert property (p_core_cap) else $error("core rate above cap");

  property p_core_full;
    (lim && sysf == 3'h3) [*4] |-> core_rate_code == 3'h3;
  endproperty
  a_core_full: assert property (p_core_full) else $error("core rate held down");

  property p_limit_read;
    reg_rd && !reg_wr && reg_addr == `ASR_REG_CORE_LIMIT |=> reg_rdata == {15'h0000, $past(lim)};
  endproperty
  a_limit_read: assert property (p_limit_read) else $error("limit bit read back wrong");

  property p_rdata_hold;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");

  property p_unmapped;
    reg_rd && reg_addr == 16'h0200 |=> reg_rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  // Main scenarios reached
  c_launch: cover property (seq_start);
  c_launch_two: cover property (seq_start && seq_index == 2'h1);
  c_core_full: cover property (core_rate_code == 3'h3);
endmodule // asr_ctrl_sva

bind asr_ctrl asr_ctrl_sva u_sva (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_slave(port_slave),
  .core_rate_code(core_rate_code), .seq_start(seq_start), .seq_index(seq_index));

// >>> test/asr_far_end.sv
// Far-side model: frame clock masters of the three ports and domain ticks.
// Assumes the bench sets periods in ns; zero parks a frame clock low.
`timescale 1ns/1ps

module asr_far_end
(
  // Frame periods in ns, 16 bits per port
  input wire [47:0] frame_period,
  // Boundary tick enables
  input wire tick_main_run,
  input wire tick_async_run,
  // Clocks toward the block
  output wire [2:0] frame_clk_in,
  output reg main_system_clock_tick,
  output reg async_system_clock_tick
);
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_frame
      reg lvl;
      assign frame_clk_in[g] = lvl;
      // Period is read each half, so a rate change lands on a clean edge
      initial
      begin
        lvl = 1'b0;
        forever
          if (frame_period[g*16 +: 16] == 16'h0000)
            #100 lvl = 1'b0;
          else
            #(frame_period[g*16 +: 16] / 2.0) lvl = ~lvl;
      end
    end
  endgenerate

  // Unrelated phases keep the two domains apart
  initial
  begin
    main_system_clock_tick = 1'b0;
    forever #200 main_system_clock_tick = tick_main_run & ~main_system_clock_tick;
  end

  initial
  begin
    async_system_clock_tick = 1'b0;
    forever #230 async_system_clock_tick = tick_async_run & ~async_system_clock_tick;
  end
endmodule // asr_far_end

// >>> test/asr_ctrl_tb.sv
// Bench for the sample-rate control block: register rows, apply, detection.
// Assumes the far-end model drives frame clocks and boundary ticks.
`timescale 1ns/1ps

module asr_ctrl_tb;
  ////////////////////////////////////////
  reg core_clk;
  reg rst;
  reg [15:0] reg_addr;
  reg [15:0] reg_wdata;
  reg reg_wr;
  reg reg_rd;
  reg [2:0] port_slave;
  reg [47:0] frame_period;
  reg tick_main_run;
  reg tick_async_run;
  wire [15:0] reg_rdata;
  wire main_system_clock_tick;
  wire async_system_clock_tick;
  wire [2:0] frame_clk_in;
  wire [2:0] core_rate_code;
  wire [4:0] port_rate_one, port_rate_two, port_rate_three;
  wire [2:0] port_async;
  wire seq_start;
  wire [1:0] seq_index;
  integer error_cnt;
  integer n_compared;
  integer cycles;
  integer n_launch;
  integer i;
  reg [15:0] rd;
  reg [1:0] last_idx;
  // Rows: write flag, address, write data, expected read
  reg [48:0] rows [0:10];

  asr_ctrl dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .main_system_clock_tick(main_system_clock_tick),
    .async_system_clock_tick(async_system_clock_tick), .frame_clk_in(frame_clk_in), .port_slave(port_slave),
    .core_rate_code(core_rate_code), .port_rate_one(port_rate_one), .port_rate_two(port_rate_two),
    .port_rate_three(port_rate_three), .port_async(port_async), .seq_start(seq_start), .seq_index(seq_index));

  asr_far_end u_far (.frame_period(frame_period), .tick_main_run(tick_main_run), .tick_async_run(tick_async_run),
    .frame_clk_in(frame_clk_in), .main_system_clock_tick(main_system_clock_tick),
    .async_system_clock_tick(async_system_clock_tick));

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Launch counter and hang guard
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (seq_start === 1'b1)
    begin
      n_launch <= n_launch + 1;
      last_idx <= seq_index;
    end
    if (cycles == 100000)
    begin
      error_cnt = error_cnt + 1;
      stop_test;
    end
  end

  ////////////////////////////////////////
  task stop_test;
  begin
    $display("Compared %0d values, %0d wrong", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask

  task check(input [15:0] got, input [15:0] exp);
  begin
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
    end
  end
  endtask

  // Strobes are one cycle wide, changed just after an edge
  task reg_write(input [15:0] a, input [15:0] d);
  begin
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  end
  endtask

  task reg_read(input [15:0] a);
  begin
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    #1 rd = reg_rdata;
  end
  endtask

  task wait_cycles(input integer n);
  begin
    repeat (n) @(posedge core_clk);
  end
  endtask

  ////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    port_slave = 3'b101;
    frame_period = 48'h0;
    tick_main_run = 1'b0;
    tick_async_run = 1'b0;
    error_cnt = 0;
    n_compared = 0;
    cycles = 0;
    n_launch = 0;
    last_idx = 2'h0;
    rows[0] = {1'b0, 16'h0161, 16'h0, 16'h0};
    rows[1] = {1'b0, 16'h0122, 16'h0, 16'h3};
    rows[2] = {1'b1, 16'h0161, 16'hffff, 16'h1};
    rows[3] = {1'b1, 16'h0100, 16'h3, 16'h3};
    rows[4] = {1'b1, 16'h0102, 16'h4, 16'h4};
    rows[5] = {1'b1, 16'h0112, 16'h5, 16'h5};
    rows[6] = {1'b1, 16'h0122, 16'h11, 16'h3};
    rows[7] = {1'b1, 16'h0200, 16'h1234, 16'h0};
    rows[8] = {1'b1, 16'h0141, 16'h3, 16'h3};
    rows[9] = {1'b1, 16'h0142, 16'h4, 16'h4};
    rows[10] = {1'b1, 16'h0132, 16'h0, 16'h3};
    wait_cycles(8);
    rst <= 1'b0;
    for (i = 0; i < 11; i = i + 1)
    begin
      if (rows[i][48])
        reg_write(rows[i][47:32], rows[i][31:16]);
      reg_read(rows[i][47:32]);
      check(rd, rows[i][15:0]);
    end
    // Core cap follows the limit bit
    check({13'h0, core_rate_code}, 16'h0003);
    reg_write(16'h0161, 16'h0000);
    wait_cycles(4);
    check({13'h0, core_rate_code}, 16'h0002);
    // New rates wait for their own domain's boundary
    check({11'h0, port_rate_one}, 16'h0003);
    tick_main_run <= 1'b1;
    wait_cycles(200);
    reg_read(16'h0122);
    check(rd, 16'h0004);
    check({11'h0, port_rate_one}, 16'h0004);
    reg_read(16'h0132);
    check(rd, 16'h0003);
    tick_async_run <= 1'b1;
    wait_cycles(200);
    reg_read(16'h0132);
    check(rd, 16'h0005);
    reg_write(16'h0150, 16'h0003);
    wait_cycles(4);
    check({1'b0, port_rate_three, port_rate_two, port_rate_one}, 16'h1085);
    check({13'h0, port_async}, 16'h0001);
    // Detection on port one, first match silent
    frame_period[15:0] <= 16'd20834;
    reg_write(16'h0140, 16'h0001);
    wait_cycles(25000);
    check(n_launch[15:0], 16'h0000);
    reg_read(16'h0145);
    check(rd, 16'h0004);
    frame_period[15:0] <= 16'd10417;
    wait_cycles(15000);
    check(n_launch[15:0], 16'h0001);
    check({14'h0, last_idx}, 16'h0001);
    // Re-enable with startup trigger set
    reg_write(16'h0140, 16'h0000);
    reg_write(16'h0140, 16'h0011);
    wait_cycles(15000);
    check(n_launch[15:0], 16'h0002);
    check({14'h0, last_idx}, 16'h0001);
    // Port two is a master, so nothing may fire
    reg_write(16'h0140, 16'h0000);
    frame_period[31:16] <= 16'd10417;
    reg_write(16'h0140, 16'h0013);
    wait_cycles(15000);
    check(n_launch[15:0], 16'h0002);
    // Fast frame clock matches no candidate
    reg_write(16'h0140, 16'h0000);
    frame_period[15:0] <= 16'd160;
    reg_write(16'h0140, 16'h0011);
    wait_cycles(3000);
    check(n_launch[15:0], 16'h0002);
    // Second reset in mid-run
    rst <= 1'b1;
    wait_cycles(2);
    rst <= 1'b0;
    reg_read(16'h0161);
    check(rd, 16'h0000);
    check({11'h0, port_rate_one}, 16'h0003);
    stop_test;
  end
endmodule // asr_ctrl_tb
